//--- hw/bhc_fwd_decode.sv
// Forwarding decision for ISA-aliased I/O and VGA ranges
`default_nettype none
module bhc_fwd_decode (
   input  wire logic [31:0] i_io_addr,
   input  wire logic [31:0] i_mem_addr,
   input  wire logic        i_io_in_window,
   input  wire logic        i_mem_in_window,
   input  wire logic        i_io_enable,
   input  wire logic        i_mem_enable,
   input  wire logic        i_isa_en,
   input  wire logic        i_vga_en,
   input  wire logic        i_vga16,
   output logic             o_io_up,
   output logic             o_io_down,
   output logic             o_mem_down
);
   import bhc_pkg::*;

   logic       low64k;
   logic       isa_hole;
   logic       vga_io;
   logic       vga_mem;
   logic [9:0] a10;

   always_comb begin
      a10      = i_io_addr[9:0];
      low64k   = (i_io_addr[31:16] == 16'h0000);
      isa_hole = i_isa_en && low64k && (i_io_addr[9:8] != 2'h0);
      vga_io   = low64k && (!i_vga16 || i_io_addr[15:10] == 6'h00)
                 && ((a10 >= VGA_IO_A_LO && a10 <= VGA_IO_A_HI)
                 || (a10 >= VGA_IO_B_LO && a10 <= VGA_IO_B_HI));
      vga_mem  = (i_mem_addr[31:17] == VGA_MEM_TAG);
      o_io_up    = i_io_in_window && isa_hole && !(i_vga_en && vga_io);
      o_io_down  = i_io_enable && ((i_io_in_window && !isa_hole)
                   || (i_vga_en && vga_io));
      o_mem_down = i_mem_enable && (i_mem_in_window || (i_vga_en && vga_mem));
   end
endmodule : bhc_fwd_decode
`default_nettype wire

//--- hw/bhc_pkg.sv
// Package: register map, field layout, constants and carrier types of the bridge header block
`default_nettype none
package bhc_pkg;
   localparam logic [7:0]  OFS_ROM_BASE  = 8'h38;
   localparam logic [7:0]  OFS_INT_CTRL  = 8'h3C;
   localparam logic [31:0] ROM_BASE_VAL  = 32'h0000_0000;
   localparam logic [7:0]  INT_LINE_RST  = 8'h00;
   localparam logic [7:0]  PIN_REVERSE   = 8'h01;
   localparam logic [7:0]  PIN_FORWARD   = 8'h00;
   localparam int          BIT_PAR_EN    = 16;
   localparam int          BIT_SERR_EN   = 17;
   localparam int          BIT_ISA_EN    = 18;
   localparam int          BIT_VGA_EN    = 19;
   localparam int          BIT_VGA16     = 20;
   localparam int          BIT_MABORT    = 21;
   localparam int          BIT_SEC_RESET = 22;
   localparam int          BIT_FBB       = 23;
   localparam int          BIT_PRI_TMO   = 24;
   localparam int          BIT_SEC_TMO   = 25;
   localparam int          BIT_TMO_STAT  = 26;
   localparam int          BIT_DT_SERR   = 27;
   localparam logic [15:0] DISCARD_LONG  = 16'h8000;
   localparam logic [15:0] DISCARD_SHORT = 16'h0400;
   localparam logic [14:0] VGA_MEM_TAG   = 15'h0005;
   localparam logic [9:0]  VGA_IO_A_LO   = 10'h3B0;
   localparam logic [9:0]  VGA_IO_A_HI   = 10'h3BB;
   localparam logic [9:0]  VGA_IO_B_LO   = 10'h3C0;
   localparam logic [9:0]  VGA_IO_B_HI   = 10'h3DF;
   localparam int          SYNC_W        = 2;
   localparam int          SYNC_MODE     = 0;
   localparam int          SYNC_SERR_N   = 1;
   localparam logic [1:0]  SYNC_RST      = 2'h2;

   typedef enum logic [0:0] {
      BHC_IDLE   = 1'b0,
      BHC_ANSWER = 1'b1
   } bhc_bus_t;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [7:0]  address;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } bhc_avs_req_t;

   typedef struct packed {
      logic        waitrequest;
      logic [31:0] readdata;
   } bhc_avs_rsp_t;

   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
   } bhc_sync_t;

   typedef struct packed {
      bhc_bus_t    bus;
      logic        wait_req;
      logic [31:0] rdata;
      logic [7:0]  int_line;
      logic        par_en;
      logic        serr_en;
      logic        isa_en;
      logic        vga_en;
      logic        vga16;
      logic        mabort;
      logic        sec_reset;
      logic        pri_tmo;
      logic        sec_tmo;
      logic        tmo_stat;
      logic        dt_serr;
      logic        serr_prev;
      logic        par_resp;
      logic        mpe_set;
      logic        err_msg;
      logic        err_fatal;
      logic        sys_err_n;
      logic        pri_sys_err_n;
      logic        tgt_abort;
      logic        fill_ones;
      logic        drop_wr;
      logic        sec_rst_n;
      logic        hot_rst;
      logic        io_up;
      logic        io_down;
      logic        mem_down;
      logic [15:0] pri_len;
      logic [15:0] sec_len;
   } bhc_state_t;
endpackage : bhc_pkg
`default_nettype wire

//--- hw/bhc_regs.sv
// Bridge header control registers at 38h and 3Ch with their control and status effects
//
// Local design decision: the Avalon-MM interface to the registers.
`default_nettype none
module bhc_regs (
   input  wire logic                  i_ref_clk,
   input  wire logic                  i_srst,
   input  wire bhc_pkg::bhc_avs_req_t i_avs_req,
   output bhc_pkg::bhc_avs_rsp_t      o_avs_rsp,
   input  wire logic                  i_mode_reverse,
   input  wire logic                  i_sec_serr_n,
   input  wire logic                  i_err_fatal_sel,
   input  wire logic                  i_poisoned_rx_p,
   input  wire logic                  i_discard_expire_p,
   input  wire logic                  i_master_abort_p,
   input  wire logic                  i_abort_is_read,
   input  wire logic                  i_tabort_possible,
   input  wire logic                  i_serr_enable,
   input  wire logic [31:0]           i_io_addr,
   input  wire logic [31:0]           i_mem_addr,
   input  wire logic                  i_io_in_window,
   input  wire logic                  i_mem_in_window,
   input  wire logic                  i_io_enable,
   input  wire logic                  i_mem_enable,
   output logic                       o_reverse_mode,
   output logic                       o_sec_parity_respond,
   output logic                       o_master_parity_set_p,
   output logic                       o_err_msg_p,
   output logic                       o_err_msg_fatal,
   output logic                       o_system_error_signal_n,
   output logic                       o_primary_system_error_out_n,
   output logic                       o_target_abort_p,
   output logic                       o_abort_fill_ones_p,
   output logic                       o_abort_drop_write_p,
   output logic                       o_sec_bus_reset_n,
   output logic                       o_hot_reset,
   output logic                       o_io_upstream,
   output logic                       o_io_downstream,
   output logic                       o_mem_downstream,
   output logic [15:0]                o_pri_discard_len,
   output logic [15:0]                o_sec_discard_len
);
   import bhc_pkg::*;

   bhc_state_t          st_reg;
   bhc_state_t          st_next;
   logic [SYNC_W-1:0]   pin_s;
   logic                rev;
   logic                serr_n;
   logic                dec_io_up;
   logic                dec_io_down;
   logic                dec_mem_down;
   logic                hit38;
   logic                hit3c;
   logic                take;
   logic                wr3c;
   logic                serr_fell;
   logic                w1c;
   logic [31:0]         rd3c;
   logic [31:0]         wd;
   logic [3:0]          be;

   bhc_sync u_sync (
      .i_ref_clk (i_ref_clk),
      .i_srst    (i_srst),
      .i_pin     ({i_sec_serr_n, i_mode_reverse}),
      .o_level   (pin_s)
   );

   assign rev    = pin_s[SYNC_MODE];
   assign serr_n = pin_s[SYNC_SERR_N];

   bhc_fwd_decode u_dec (
      .i_io_addr       (i_io_addr),
      .i_mem_addr      (i_mem_addr),
      .i_io_in_window  (i_io_in_window),
      .i_mem_in_window (i_mem_in_window),
      .i_io_enable     (i_io_enable),
      .i_mem_enable    (i_mem_enable),
      .i_isa_en        (st_reg.isa_en),
      .i_vga_en        (st_reg.vga_en),
      .i_vga16         (st_reg.vga16),
      .o_io_up         (dec_io_up),
      .o_io_down       (dec_io_down),
      .o_mem_down      (dec_mem_down)
   );

   always_comb begin
      st_next   = st_reg;
      wd        = i_avs_req.writedata;
      be        = i_avs_req.byteenable;
      hit38     = (i_avs_req.address[7:2] == OFS_ROM_BASE[7:2]);
      hit3c     = (i_avs_req.address[7:2] == OFS_INT_CTRL[7:2]);
      take      = (st_reg.bus == BHC_IDLE) && (i_avs_req.read || i_avs_req.write);
      wr3c      = take && i_avs_req.write && hit3c;
      w1c       = wr3c && be[3] && wd[BIT_TMO_STAT];
      serr_fell = st_reg.serr_prev && !serr_n;

      // Readback of the 3Ch word; fields that are read-only in this mode read zero, except the pin byte, which reads 01h in reverse mode
      rd3c                = 32'h0000_0000;
      rd3c[7:0]           = rev ? st_reg.int_line : 8'h00;
      rd3c[15:8]          = rev ? PIN_REVERSE : PIN_FORWARD;
      rd3c[BIT_PAR_EN]    = st_reg.par_en;
      rd3c[BIT_SERR_EN]   = st_reg.serr_en && !rev;
      rd3c[BIT_ISA_EN]    = st_reg.isa_en;
      rd3c[BIT_VGA_EN]    = st_reg.vga_en;
      rd3c[BIT_VGA16]     = st_reg.vga16;
      rd3c[BIT_MABORT]    = st_reg.mabort;
      rd3c[BIT_SEC_RESET] = st_reg.sec_reset;
      rd3c[BIT_FBB]       = 1'b0;
      rd3c[BIT_PRI_TMO]   = st_reg.pri_tmo && rev;
      rd3c[BIT_SEC_TMO]   = st_reg.sec_tmo && !rev;
      rd3c[BIT_TMO_STAT]  = st_reg.tmo_stat;
      rd3c[BIT_DT_SERR]   = st_reg.dt_serr;

      // Bus handshake: one wait cycle, then a single answer cycle
      st_next.bus      = take ? BHC_ANSWER : BHC_IDLE;
      st_next.wait_req = !take;
      if (take && i_avs_req.read) begin
         if (hit38) begin
            st_next.rdata = ROM_BASE_VAL;
         end else if (hit3c) begin
            st_next.rdata = rd3c;
         end else begin
            st_next.rdata = 32'h0000_0000;
         end
      end

      if (wr3c) begin
         if (be[0] && rev) begin
            st_next.int_line = wd[7:0];
         end
         if (be[2]) begin
            st_next.par_en    = wd[BIT_PAR_EN];
            st_next.isa_en    = wd[BIT_ISA_EN];
            st_next.vga_en    = wd[BIT_VGA_EN];
            st_next.vga16     = wd[BIT_VGA16];
            st_next.mabort    = wd[BIT_MABORT];
            st_next.sec_reset = wd[BIT_SEC_RESET];
            if (!rev) begin
               st_next.serr_en = wd[BIT_SERR_EN];
            end
         end
         if (be[3]) begin
            st_next.dt_serr = wd[BIT_DT_SERR];
            if (rev) begin
               st_next.pri_tmo = wd[BIT_PRI_TMO];
            end else begin
               st_next.sec_tmo = wd[BIT_SEC_TMO];
            end
         end
      end

      // A new expiry wins over a clearing write in the same cycle
      st_next.tmo_stat = (st_reg.tmo_stat && !w1c) || i_discard_expire_p;

      st_next.serr_prev = serr_n;
      st_next.par_resp  = !rev && st_reg.par_en;
      st_next.mpe_set   = rev && st_reg.par_en && i_poisoned_rx_p;
      st_next.err_msg   = !rev && ((st_reg.serr_en && serr_fell)
                          || (st_reg.dt_serr && i_discard_expire_p));
      st_next.err_fatal = i_err_fatal_sel;
      st_next.pri_sys_err_n = !(rev && st_reg.dt_serr && i_discard_expire_p);
      st_next.fill_ones = i_master_abort_p && !st_reg.mabort && i_abort_is_read;
      st_next.drop_wr   = i_master_abort_p && !st_reg.mabort && !i_abort_is_read;
      st_next.tgt_abort = i_master_abort_p && st_reg.mabort && i_tabort_possible;
      st_next.sys_err_n = !(i_master_abort_p && st_reg.mabort && !i_tabort_possible
                          && i_serr_enable);
      st_next.sec_rst_n = !(!rev && st_reg.sec_reset);
      st_next.hot_rst   = rev && st_reg.sec_reset;
      st_next.pri_len   = (rev && st_reg.pri_tmo) ? DISCARD_SHORT : DISCARD_LONG;
      st_next.sec_len   = (!rev && st_reg.sec_tmo) ? DISCARD_SHORT : DISCARD_LONG;
      st_next.io_up     = dec_io_up;
      st_next.io_down   = dec_io_down;
      st_next.mem_down  = dec_mem_down;
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         st_reg               <= '0;
         st_reg.bus           <= BHC_IDLE;
         st_reg.wait_req      <= 1'b1;
         st_reg.int_line      <= INT_LINE_RST;
         st_reg.serr_prev     <= 1'b1;
         st_reg.sys_err_n     <= 1'b1;
         st_reg.pri_sys_err_n <= 1'b1;
         st_reg.sec_rst_n     <= 1'b1;
         st_reg.pri_len       <= DISCARD_LONG;
         st_reg.sec_len       <= DISCARD_LONG;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_avs_rsp.waitrequest      = st_reg.wait_req;
   assign o_avs_rsp.readdata         = st_reg.rdata;
   assign o_reverse_mode             = pin_s[SYNC_MODE];
   assign o_sec_parity_respond       = st_reg.par_resp;
   assign o_master_parity_set_p      = st_reg.mpe_set;
   assign o_err_msg_p                = st_reg.err_msg;
   assign o_err_msg_fatal            = st_reg.err_fatal;
   assign o_system_error_signal_n    = st_reg.sys_err_n;
   assign o_primary_system_error_out_n = st_reg.pri_sys_err_n;
   assign o_target_abort_p           = st_reg.tgt_abort;
   assign o_abort_fill_ones_p        = st_reg.fill_ones;
   assign o_abort_drop_write_p       = st_reg.drop_wr;
   assign o_sec_bus_reset_n          = st_reg.sec_rst_n;
   assign o_hot_reset                = st_reg.hot_rst;
   assign o_io_upstream              = st_reg.io_up;
   assign o_io_downstream            = st_reg.io_down;
   assign o_mem_downstream           = st_reg.mem_down;
   assign o_pri_discard_len          = st_reg.pri_len;
   assign o_sec_discard_len          = st_reg.sec_len;

   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_srst);

   a_rom_zero_read: assert property (
      (take && i_avs_req.read && hit38) |=> (!o_avs_rsp.waitrequest
         && o_avs_rsp.readdata == 32'h0000_0000))
      else $error("ROM base read not zero");

   a_pin_byte_value: assert property (
      (take && i_avs_req.read && hit3c && $stable(rev)) |=>
         (o_avs_rsp.readdata[15:8] == (rev ? 8'h01 : 8'h00)))
      else $error("Interrupt pin byte wrong for mode");

   a_int_line_fwd: assert property (
      !rev |=> $stable(st_reg.int_line))
      else $error("Interrupt line changed in forward mode");

   a_fbb_zero_read: assert property (
      (take && i_avs_req.read && hit3c) |=> !o_avs_rsp.readdata[23])
      else $error("Fast back-to-back bit read as one");

   a_poison_gate: assert property (
      o_master_parity_set_p |-> $past(i_poisoned_rx_p && rev && st_reg.par_en))
      else $error("Parity status set without gated cause");

   a_serr_forward: assert property (
      (serr_fell && !rev && st_reg.serr_en) |=> o_err_msg_p)
      else $error("Secondary system error not forwarded");

   a_abort_ones: assert property (
      (i_master_abort_p && !st_reg.mabort && i_abort_is_read) |=>
         (o_abort_fill_ones_p && !o_target_abort_p))
      else $error("Unreported abort did not return all ones");

   a_abort_report: assert property (
      (i_master_abort_p && st_reg.mabort && i_tabort_possible) |=>
         (o_target_abort_p && o_system_error_signal_n && !o_abort_fill_ones_p))
      else $error("Reported abort did not signal target abort");

   a_sec_reset_hold: assert property (
      (!rev && st_reg.sec_reset) [*2] |=> !o_sec_bus_reset_n)
      else $error("Secondary bus reset not held");

   a_hot_reset_follow: assert property (
      (rev && !st_reg.sec_reset) |=> !o_hot_reset)
      else $error("Hot reset driven while bit clear");

   a_status_sticky: assert property (
      i_discard_expire_p |=> st_reg.tmo_stat [*2] or ##1 (st_reg.tmo_stat && w1c))
      else $error("Discard status not set by expiry");

   a_pri_serr_expire: assert property (
      (rev && st_reg.dt_serr && i_discard_expire_p) |=> !o_primary_system_error_out_n)
      else $error("Primary system error not asserted on expiry");

   a_pri_len_fwd: assert property (
      !rev |=> (o_pri_discard_len == 16'h8000))
      else $error("Primary timer length changed in forward mode");

   c_bus_write: cover property (wr3c ##1 !o_avs_rsp.waitrequest);
   c_expire_clear: cover property (i_discard_expire_p && w1c);
   c_hot_reset: cover property ($rose(o_hot_reset));
   c_isa_upstream: cover property (o_io_upstream);
endmodule : bhc_regs
`default_nettype wire

//--- hw/bhc_sync.sv
// Two-flop synchronisers for the pin inputs of the header block
`default_nettype none
module bhc_sync (
   input  wire logic                      i_ref_clk,
   input  wire logic                      i_srst,
   input  wire logic [bhc_pkg::SYNC_W-1:0] i_pin,
   output logic      [bhc_pkg::SYNC_W-1:0] o_level
);
   import bhc_pkg::*;

   bhc_sync_t st_reg;
   bhc_sync_t st_next;

   always_comb begin
      st_next    = st_reg;
      st_next.s1 = i_pin;
      st_next.s2 = st_reg.s1;
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         st_reg <= '{s1: SYNC_RST, s2: SYNC_RST};
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_level = st_reg.s2;
endmodule : bhc_sync
`default_nettype wire

//--- test/bhc_regs_tb.sv
// Self-checking testbench for the bridge header control registers
`default_nettype none
module bhc_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import bhc_pkg::*;

   logic         i_ref_clk = 1'h0;
   logic         i_srst    = 1'h1;
   bhc_avs_req_t req       = '0;
   bhc_avs_rsp_t rsp;
   logic         mode_rev  = 1'h0;
   logic         serr_n    = 1'h1;
   logic         fatal_sel = 1'h1;
   logic         poison_p  = 1'h0;
   logic         expire_p  = 1'h0;
   logic         abort_p   = 1'h0;
   logic         abort_rd  = 1'h0;
   logic         tab_ok    = 1'h0;
   logic         serr_en   = 1'h0;
   logic [31:0]  io_addr   = 32'h0;
   logic [31:0]  mem_addr  = 32'h0;
   logic         io_win    = 1'h0;
   logic         mem_win   = 1'h0;
   logic         io_en     = 1'h1;
   logic         mem_en    = 1'h1;
   logic         rev_mode, par_resp, mpe_p, err_p, err_fatal, sys_n, psys_n;
   logic         tab_p, fill_p, drop_p, sec_rst_n, hot_rst, io_up, io_dn, mem_dn;
   logic [15:0]  pri_len, sec_len;
   logic [6:0]   obs;
   logic [31:0]  rd;
   int           err_total = 0;
   int           n_tests   = 0;

   // Event outputs gathered active high: bit 0 message, 1 system error, 2 primary error,
   // 3 target abort, 4 fill ones, 5 drop write, 6 parity status
   assign obs = {mpe_p, drop_p, fill_p, tab_p, ~psys_n, ~sys_n, err_p};

   always #50 i_ref_clk = ~i_ref_clk;

   bhc_regs uut (
      .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_avs_req(req), .o_avs_rsp(rsp),
      .i_mode_reverse(mode_rev), .i_sec_serr_n(serr_n), .i_err_fatal_sel(fatal_sel),
      .i_poisoned_rx_p(poison_p), .i_discard_expire_p(expire_p),
      .i_master_abort_p(abort_p), .i_abort_is_read(abort_rd),
      .i_tabort_possible(tab_ok), .i_serr_enable(serr_en), .i_io_addr(io_addr),
      .i_mem_addr(mem_addr), .i_io_in_window(io_win), .i_mem_in_window(mem_win),
      .i_io_enable(io_en), .i_mem_enable(mem_en), .o_reverse_mode(rev_mode),
      .o_sec_parity_respond(par_resp), .o_master_parity_set_p(mpe_p),
      .o_err_msg_p(err_p), .o_err_msg_fatal(err_fatal),
      .o_system_error_signal_n(sys_n), .o_primary_system_error_out_n(psys_n),
      .o_target_abort_p(tab_p), .o_abort_fill_ones_p(fill_p),
      .o_abort_drop_write_p(drop_p), .o_sec_bus_reset_n(sec_rst_n),
      .o_hot_reset(hot_rst), .o_io_upstream(io_up), .o_io_downstream(io_dn),
      .o_mem_downstream(mem_dn), .o_pri_discard_len(pri_len), .o_sec_discard_len(sec_len)
   );

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : final_report

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      int i;
      @(posedge i_ref_clk);
      req <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: be};
      for (i = 0; i < 20; i++) begin
         @(posedge i_ref_clk);
         if (rsp.waitrequest === 1'h0) break;
      end
      if (i == 20) begin
         check("bus answer", 32'h0, 32'h1);
         final_report();
      end
      rd = rsp.readdata;
      req <= '0;
   endtask : bus

   task automatic settle();
      repeat (2) @(posedge i_ref_clk);
      #1;
   endtask : settle

   task automatic reset_dut(input logic rev);
      @(posedge i_ref_clk);
      i_srst <= 1'h1;
      mode_rev <= rev;
      repeat (4) @(posedge i_ref_clk);
      i_srst <= 1'h0;
      repeat (3) @(posedge i_ref_clk);
   endtask : reset_dut

   // Watches one event output for six cycles and judges whether it pulsed
   task automatic watch(input int b, input logic exp, input string name);
      logic seen;
      seen = 1'h0;
      repeat (6) begin
         #1;
         if (obs[b] === 1'h1) seen = 1'h1;
         @(posedge i_ref_clk);
      end
      check(name, {31'h0, seen}, {31'h0, exp});
   endtask : watch

   task automatic pulse(input int k);
      @(posedge i_ref_clk);
      case (k)
         0: expire_p <= 1'h1;
         1: abort_p <= 1'h1;
         default: poison_p <= 1'h1;
      endcase
      @(posedge i_ref_clk);
      {expire_p, abort_p, poison_p} <= 3'h0;
   endtask : pulse

   task automatic abort(input logic r, input logic t, input logic s);
      @(posedge i_ref_clk);
      abort_rd <= r;
      tab_ok <= t;
      serr_en <= s;
      pulse(1);
   endtask : abort

   task automatic serr_fall();
      @(posedge i_ref_clk);
      serr_n <= 1'h0;
   endtask : serr_fall

   task automatic dec(input logic [31:0] io, input logic [31:0] mem, input logic win);
      @(posedge i_ref_clk);
      io_addr <= io;
      mem_addr <= mem;
      io_win <= win;
      mem_win <= win;
      settle();
   endtask : dec

   task automatic sc_fwd_regs();
      reset_dut(1'h0);
      bus(0, OFS_ROM_BASE, 32'h0, 4'hF);
      check("rom base", rd, ROM_BASE_VAL);
      bus(0, OFS_INT_CTRL, 32'h0, 4'hF);
      check("ctrl reset", rd, 32'h0);
      check("pri len reset", {16'h0, pri_len}, {16'h0, DISCARD_LONG});
      bus(1, OFS_ROM_BASE, 32'hFFFF_FFFF, 4'hF);
      bus(0, OFS_ROM_BASE, 32'h0, 4'hF);
      check("rom base write", rd, 32'h0);
      bus(0, 8'h40, 32'h0, 4'hF);
      check("unmapped", rd, 32'h0);
      bus(1, OFS_INT_CTRL, 32'hFFFF_FFFF, 4'hF);
      bus(0, OFS_INT_CTRL, 32'h0, 4'hF);
      check("ctrl forward", rd, 32'h0A7F_0000);
      settle();
      check("parity respond", {31'h0, par_resp}, 32'h1);
      check("sec reset", {31'h0, sec_rst_n}, 32'h0);
      check("sec len", {16'h0, sec_len}, {16'h0, DISCARD_SHORT});
      check("pri len fwd", {16'h0, pri_len}, {16'h0, DISCARD_LONG});
      check("mode forward", {31'h0, rev_mode}, 32'h0);
      check("severity fatal", {31'h0, err_fatal}, 32'h1);
      fatal_sel <= 1'h0;
      settle();
      check("severity nonfatal", {31'h0, err_fatal}, 32'h0);
      fatal_sel <= 1'h1;
   endtask : sc_fwd_regs

   task automatic sc_fwd_events();
      serr_fall();
      watch(0, 1'h1, "serr message");
      serr_n <= 1'h1;
      abort(1'h1, 1'h1, 1'h1);
      watch(3, 1'h1, "target abort");
      abort(1'h1, 1'h0, 1'h1);
      watch(1, 1'h1, "abort serr");
      abort(1'h1, 1'h0, 1'h0);
      watch(1, 1'h0, "abort serr off");
      pulse(0);
      watch(0, 1'h1, "discard message");
      bus(0, OFS_INT_CTRL, 32'h0, 4'hF);
      check("discard status", rd, 32'h0E7F_0000);
      bus(1, OFS_INT_CTRL, 32'h0A00_0000, 4'h8);
      bus(0, OFS_INT_CTRL, 32'h0, 4'hF);
      check("status keep", rd, 32'h0E7F_0000);
      bus(1, OFS_INT_CTRL, 32'h0E00_0000, 4'h8);
      bus(0, OFS_INT_CTRL, 32'h0, 4'hF);
      check("status clear", rd, 32'h0A7F_0000);
      bus(1, OFS_INT_CTRL, 32'h0, 4'hF);
      settle();
      check("sec reset off", {31'h0, sec_rst_n}, 32'h1);
      check("parity off", {31'h0, par_resp}, 32'h0);
      abort(1'h1, 1'h1, 1'h1);
      watch(4, 1'h1, "fill ones");
      abort(1'h0, 1'h1, 1'h1);
      watch(5, 1'h1, "drop write");
      serr_fall();
      watch(0, 1'h0, "serr off");
      serr_n <= 1'h1;
      pulse(0);
      watch(0, 1'h0, "discard quiet");
      bus(0, OFS_INT_CTRL, 32'h0, 4'hF);
      check("status only", rd, 32'h0400_0000);
   endtask : sc_fwd_events

   task automatic sc_decode();
      bus(1, OFS_INT_CTRL, 32'h0004_0000, 4'hF);
      dec(32'h0000_0100, 32'h0, 1'h1);
      check("isa alias", {31'h0, io_up}, 32'h1);
      dec(32'h0000_00C0, 32'h0, 1'h1);
      check("isa low", {31'h0, io_up}, 32'h0);
      dec(32'h0001_0100, 32'h0, 1'h1);
      check("isa above 64k", {31'h0, io_up}, 32'h0);
      bus(1, OFS_INT_CTRL, 32'h0008_0000, 4'hF);
      dec(32'h0000_03C0, 32'h000A_0000, 1'h0);
      check("vga io", {31'h0, io_dn}, 32'h1);
      check("vga mem", {31'h0, mem_dn}, 32'h1);
      dec(32'h0000_07C0, 32'h0, 1'h0);
      check("vga 10 bit", {31'h0, io_dn}, 32'h1);
      bus(1, OFS_INT_CTRL, 32'h0018_0000, 4'hF);
      dec(32'h0000_07C0, 32'h0, 1'h0);
      check("vga 16 alias", {31'h0, io_dn}, 32'h0);
      dec(32'h0000_03C0, 32'h0, 1'h0);
      check("vga 16 hit", {31'h0, io_dn}, 32'h1);
      bus(1, OFS_INT_CTRL, 32'h0, 4'hF);
      dec(32'h0000_03C0, 32'h000A_0000, 1'h0);
      check("vga off io", {31'h0, io_dn}, 32'h0);
      check("vga off mem", {31'h0, mem_dn}, 32'h0);
   endtask : sc_decode

   task automatic sc_reverse();
      reset_dut(1'h1);
      bus(0, OFS_INT_CTRL, 32'h0, 4'hF);
      check("ctrl reverse", rd, {16'h0, PIN_REVERSE, INT_LINE_RST});
      bus(1, OFS_INT_CTRL, 32'hFFFF_FF5A, 4'hF);
      bus(0, OFS_INT_CTRL, 32'h0, 4'hF);
      check("ctrl rev write", rd, 32'h097D_015A);
      settle();
      check("hot reset", {31'h0, hot_rst}, 32'h1);
      check("sec bus rev", {31'h0, sec_rst_n}, 32'h1);
      check("pri len rev", {16'h0, pri_len}, {16'h0, DISCARD_SHORT});
      check("sec len rev", {16'h0, sec_len}, {16'h0, DISCARD_LONG});
      check("mode reverse", {31'h0, rev_mode}, 32'h1);
      pulse(2);
      watch(6, 1'h1, "poison status");
      pulse(0);
      watch(2, 1'h1, "primary error");
      bus(1, OFS_INT_CTRL, 32'h0, 4'hF);
      settle();
      check("hot reset off", {31'h0, hot_rst}, 32'h0);
      pulse(2);
      watch(6, 1'h0, "poison quiet");
   endtask : sc_reverse

   initial begin
      sc_fwd_regs();
      sc_fwd_events();
      sc_decode();
      sc_reverse();
      final_report();
   end
endmodule : bhc_regs_tb
`default_nettype wire
